// >>> common/adc_ctrl_pkg.sv
// Purpose: Shared constants, field layout and mode types for the converter serial control word.
// Assumes: 12-bit command word, 16-edge frame, 16 analog inputs.
// Notes:   Decode helpers live here; both clock domains use the sequencer decode, only the system domain the power decode.
`default_nettype none

package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int CFG_W = 12; // Configuration word width
    localparam int CHAN_W = 4; // Channel address width
    localparam int RESULT_W = 12; // Conversion result width
    localparam int FRAME_W = 16; // Bits per framed transfer
    localparam int CNT_W = 5; // Edge counter width
    localparam logic [4:0] CNT_ONE = 5'h01; // Counter step
    localparam logic [4:0] CNT_CMD_LAST = 5'h0b; // Count before the 12th falling edge
    localparam logic [4:0] CNT_MUX = 5'h0d; // Count before the 14th falling edge
    localparam logic [4:0] CNT_FRAME_END = 5'h10; // Count after the 16th falling edge
    localparam logic [4:0] CNT_TOP_BIT = 5'h0f; // Index of first bit on the result line

    // ------------------------------------------------------------
    // Field positions in the configuration word
    // ------------------------------------------------------------
    localparam int WRITE_BIT = 11; // Update enable
    localparam int SEQ_BIT = 10; // sequence_enable
    localparam int ADDR_HI = 9; // chan_addr_bit3
    localparam int ADDR_LO = 6; // chan_addr_bit0
    localparam int PWR_HI = 5; // power_sel_hi
    localparam int PWR_LO = 4; // power_sel_lo
    localparam int CHSET_BIT = 3; // Channel-set access
    localparam int WEAK_BIT = 2; // Idle weak drive of the result line
    localparam int RANGE_BIT = 1; // Input span select
    localparam int CODING_BIT = 0; // Output coding select
    localparam logic [11:0] CFG_RESET = 12'h030; // Normal power, single channel 0
    localparam logic [3:0] CHAN_ZERO = 4'h0; // First channel of a consecutive run
    localparam logic [3:0] CHAN_ONE = 4'h1; // Channel step

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40; // ref_clk period
    localparam int WAKE_TIME_NS = 1000; // Wake-up time from auto shutdown
    localparam logic [5:0] WAKE_CYCLES = 6'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] WAKE_ZERO = 6'h00; // Wake timer expired
    localparam logic [5:0] WAKE_STEP = 6'h01; // Wake timer step

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_AUTO_STANDBY,
        PWR_AUTO_SHUTDOWN,
        PWR_FULL_SHUTDOWN,
        PWR_NORMAL
    } power_mode_e;

    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_LOAD_SET,
        SEQ_KEEP,
        SEQ_RANGE
    } seq_mode_e;

    // Power field decode
    function automatic power_mode_e decode_power(input logic [11:0] cfg);
        power_mode_e m;
        m = PWR_NORMAL;
        unique case ({cfg[PWR_HI], cfg[PWR_LO]})
            2'b11: m = PWR_NORMAL;
            2'b10: m = PWR_FULL_SHUTDOWN;
            2'b01: m = PWR_AUTO_SHUTDOWN;
            2'b00: m = PWR_AUTO_STANDBY;
        endcase
        return m;
    endfunction

    // Sequencer pair decode: sequence enable with channel-set access
    function automatic seq_mode_e decode_seq(input logic [11:0] cfg);
        seq_mode_e m;
        m = SEQ_OFF;
        unique case ({cfg[SEQ_BIT], cfg[CHSET_BIT]})
            2'b00: m = SEQ_OFF;
            2'b01: m = SEQ_LOAD_SET;
            2'b10: m = SEQ_KEEP;
            2'b11: m = SEQ_RANGE;
        endcase
        return m;
    endfunction

endpackage

`default_nettype wire

// >>> hdl/sync_2ff.sv
// Purpose: Two-flop level synchroniser, one chain per bit.
// Assumes: Inputs are levels that stay put for at least two destination clocks.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ------------------------------------------------------------
    // Synchroniser chains
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg; // Second stage
    logic [WIDTH-1:0] q_next;

    // Next values
    always_comb begin
        meta_next = d;
        q_next = meta_reg;
        if (rst) begin
            meta_next = '0;
            q_next = '0;
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        meta_reg <= meta_next;
        q_reg <= q_next;
    end

    assign q = q_reg;

endmodule

`default_nettype wire

// >>> hdl/adc_serial_control_word.sv
// Purpose: Serial command side of a 16-channel sampling converter: captures the
//          configuration word, steers the input mux and shifts out results.
// Assumes: Host frames with cs_n, drives sclk and din; results come from a core on ref_clk.
// Notes:   Link logic runs on the falling edge of sclk; config crosses by toggle.
//
// Summary of operation
// R01: Hold a twelve-bit write-only configuration word
// R02: Sample command bits on sclk falling edges
// R03: Command shifts in while previous result shifts out
// R04: Host gives sixteen sclk cycles per frame
// R05: Only first twelve edges after cs_n fall count
// R06: Command word arrives most significant bit first
// R07: Bit eleven set commits, clear discards word
// R08: Sequence enable and channel-set bits decoded together
// R09: Address bits pick next or final channel
// R10: Address field decodes as unsigned channel number
// R11: Mux switches on fourteenth falling edge
// R12: Channel address precedes twelve result bits
// R13: Bits five and four select power mode
// R14: Bit two chooses weak idle drive or release
// R15: Bit one selects input span
// R16: Bit zero selects output coding
// R17: Power field decodes to four operating modes
// R18: Sequencer pair decodes to four sequencer modes
// R19: Commit only after all twelve bits captured
// R20: Frame is cs_n low, count restarts each fall
`default_nettype none

module adc_serial_control_word
    import adc_ctrl_pkg::*;
#(
    parameter int RES_W = RESULT_W,
    parameter int ADDR_W = CHAN_W
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_o,
    output logic dout_oe,
    output logic dout_weak,
    // Input mux select, link clock domain
    output logic [ADDR_W-1:0] mux_chan,
    // Conversion core handshake
    input wire logic [RES_W-1:0] conv_result,
    input wire logic conv_result_valid,
    output logic conv_result_ready,
    output logic conv_start,
    // Configuration seen by the core
    output logic [CFG_W-1:0] conversion_config_word,
    output logic cfg_update,
    output logic [ADDR_W-1:0] chan_addr,
    output power_mode_e power_mode,
    output seq_mode_e seq_mode,
    output logic weak_idle,
    output logic range_single_ref,
    output logic coding_binary,
    output logic analog_powered,
    output logic bias_powered
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The frame carries exactly the address ahead of the result
    if (RES_W + ADDR_W != FRAME_W) begin : g_bad_width
        $error("Address and result widths must fill one frame");
    end
    if (ADDR_W != ADDR_HI - ADDR_LO + 1) begin : g_bad_addr
        $error("Address width must match the address field");
    end

    // ------------------------------------------------------------
    // Link domain: frame counter and command shifter
    // ------------------------------------------------------------
    logic frame_clr; // Holds the counter clear between frames
    logic [CNT_W-1:0] cnt_reg; // Falling edges seen in this frame
    logic [CNT_W-1:0] cnt_next;
    logic [CFG_W-2:0] shift_reg; // First eleven command bits
    logic [CFG_W-2:0] shift_next;
    logic [CFG_W-1:0] cmd_word; // Complete word as the 12th bit arrives

    // Count restarts whenever cs_n is high; reset also clears it
    assign frame_clr = cs_n | sys_rst; // R20

    // Word as it stands on the 12th edge, first bit at the top
    assign cmd_word = {shift_reg, din}; // R06

    // Next count and shift values
    always_comb begin
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        // Saturate after the frame so extra edges change nothing
        if (cnt_reg != CNT_FRAME_END) begin
            cnt_next = cnt_reg + CNT_ONE;
        end
        // First eleven edges shift; the 12th comes straight from din
        if (cnt_reg < CNT_CMD_LAST) begin // R05
            shift_next = {shift_reg[CFG_W-3:0], din}; // R02 R06
        end
    end

    // Counter clears asynchronously on cs_n high, since sclk may be idle then
    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            cnt_reg <= '0;
            shift_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------
    // Link domain: configuration copy, sequencer and mux
    // ------------------------------------------------------------
    logic [CFG_W-1:0] cfg_link_reg; // Active config as the link sees it
    logic [CFG_W-1:0] cfg_link_next;
    logic cfg_tgl_reg; // Flips once per committed word
    logic cfg_tgl_next;
    logic [ADDR_W-1:0] mux_reg; // Channel on the mux
    logic [ADDR_W-1:0] mux_next;
    logic [ADDR_W-1:0] seq_last_reg; // Final channel of a consecutive run
    logic [ADDR_W-1:0] seq_last_next;
    logic seq_run_reg; // Consecutive run in progress
    logic seq_run_next;
    logic [ADDR_W-1:0] link_addr; // Address field of the active config
    seq_mode_e link_seq; // Sequencer mode of the active config

    assign link_addr = ADDR_W'(cfg_link_reg[ADDR_HI:ADDR_LO]); // R10
    assign link_seq = decode_seq(cfg_link_reg); // R08 R18

    // Next config, sequencer and mux values
    always_comb begin
        cfg_link_next = cfg_link_reg;
        cfg_tgl_next = cfg_tgl_reg;
        mux_next = mux_reg;
        seq_last_next = seq_last_reg;
        seq_run_next = seq_run_reg;
        // Commit only on the 12th edge, so a frame cut before edge 12 changes nothing
        if (cnt_reg == CNT_CMD_LAST) begin // R19
            if (cmd_word[WRITE_BIT]) begin // R07 R01
                cfg_link_next = cmd_word;
                cfg_tgl_next = ~cfg_tgl_reg;
                // A fresh consecutive run restarts at channel zero
                if (decode_seq(cmd_word) == SEQ_RANGE) begin // R18
                    seq_run_next = 1'b0;
                    seq_last_next = ADDR_W'(cmd_word[ADDR_HI:ADDR_LO]); // R09
                end
            end
        end
        // Channel for the following conversion goes to the mux on edge 14
        if (cnt_reg == CNT_MUX) begin // R11 R03
            unique case (link_seq)
                SEQ_RANGE, SEQ_KEEP: begin
                    // Keep mode only continues a run that is already going
                    if (!seq_run_reg && link_seq == SEQ_RANGE) begin
                        mux_next = CHAN_ZERO;
                        seq_run_next = 1'b1;
                    end else if (seq_run_reg) begin
                        mux_next = (mux_reg == seq_last_reg) ? CHAN_ZERO : mux_reg + CHAN_ONE; // R09
                    end else begin
                        mux_next = link_addr;
                    end
                end
                SEQ_OFF, SEQ_LOAD_SET: begin
                    // Address field picks each channel directly
                    mux_next = link_addr; // R09 R10
                    seq_run_next = 1'b0;
                end
            endcase
        end
    end

    // Config state survives between frames; only system reset clears it
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_link_reg <= CFG_RESET;
            cfg_tgl_reg <= 1'b0;
            mux_reg <= CHAN_ZERO;
            seq_last_reg <= CHAN_ZERO;
            seq_run_reg <= 1'b0;
        end else begin
            cfg_link_reg <= cfg_link_next;
            cfg_tgl_reg <= cfg_tgl_next;
            mux_reg <= mux_next;
            seq_last_reg <= seq_last_next;
            seq_run_reg <= seq_run_next;
        end
    end

    assign mux_chan = mux_reg;

    // ------------------------------------------------------------
    // Link domain: result line
    // ------------------------------------------------------------
    logic [RES_W-1:0] result_hold_reg; // Result word, ref_clk domain, steady in frames
    logic [FRAME_W-1:0] frame_word; // Address of this conversion ahead of its result
    logic in_frame; // Strong drive window
    logic [CNT_W-1:0] bit_idx; // Frame bit on the line now

    // Mux still holds this conversion's channel until edge 14, past the address bits
    assign frame_word = {mux_reg, result_hold_reg}; // R12
    assign in_frame = !cs_n && (cnt_reg != CNT_FRAME_END);
    assign bit_idx = CNT_TOP_BIT - cnt_reg;

    // Each falling edge moves the line on by one bit, top bit first
    always_comb begin
        dout_o = 1'b0;
        dout_oe = 1'b0;
        dout_weak = 1'b0;
        if (in_frame) begin
            dout_o = frame_word[bit_idx[3:0]]; // R03 R12
            dout_oe = 1'b1;
        end else if (cfg_link_reg[WEAK_BIT]) begin // R14
            // Weak hold of the next conversion's top address bit
            dout_o = mux_reg[ADDR_W-1];
            dout_oe = 1'b1;
            dout_weak = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // System domain: crossings
    // ------------------------------------------------------------
    logic [1:0] sync_q; // {config toggle, cs_n} after two flops
    logic cfg_tgl_seen_reg; // Last toggle value acted on
    logic cfg_tgl_seen_next;
    logic cs_idle_reg; // Delayed synchronised cs_n
    logic cs_idle_next;

    sync_2ff #(
        .WIDTH(2)
    ) u_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .d({cfg_tgl_reg, cs_n}),
        .q(sync_q)
    );

    // ------------------------------------------------------------
    // System domain: configuration word and result hand-off
    // ------------------------------------------------------------
    logic [CFG_W-1:0] cfg_reg; // conversion_config_word
    logic [CFG_W-1:0] cfg_next;
    logic cfg_upd_reg;
    logic cfg_upd_next;
    logic start_reg;
    logic start_next;
    logic [RES_W-1:0] result_hold_next;
    logic result_take;

    // Results swap only while no frame shifts them out
    assign conv_result_ready = sync_q[0] && cs_idle_reg;
    assign result_take = conv_result_ready && conv_result_valid;

    // Next values for the system copy
    always_comb begin
        cfg_next = cfg_reg;
        cfg_upd_next = 1'b0;
        cfg_tgl_seen_next = sync_q[1];
        cs_idle_next = sync_q[0];
        start_next = cs_idle_reg && !sync_q[0];
        result_hold_next = result_hold_reg;
        // Link word is steady long before the next commit can follow
        if (sync_q[1] != cfg_tgl_seen_reg) begin // R01 R07
            cfg_next = cfg_link_reg;
            cfg_upd_next = 1'b1;
        end
        if (result_take) begin
            result_hold_next = conv_result;
        end
        if (sys_rst) begin
            cfg_next = CFG_RESET;
            cfg_upd_next = 1'b0;
            cfg_tgl_seen_next = 1'b0;
            cs_idle_next = 1'b0; // Matches the cleared sync stage, so no false start
            start_next = 1'b0;
            result_hold_next = '0;
        end
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        cfg_reg <= cfg_next;
        cfg_upd_reg <= cfg_upd_next;
        cfg_tgl_seen_reg <= cfg_tgl_seen_next;
        cs_idle_reg <= cs_idle_next;
        start_reg <= start_next;
        result_hold_reg <= result_hold_next;
    end

    assign conversion_config_word = cfg_reg;
    assign cfg_update = cfg_upd_reg;
    assign conv_start = start_reg;

    // Field decodes for the core
    assign chan_addr = ADDR_W'(cfg_reg[ADDR_HI:ADDR_LO]); // R10
    assign power_mode = decode_power(cfg_reg); // R13 R17
    assign seq_mode = decode_seq(cfg_reg); // R08 R18
    assign weak_idle = cfg_reg[WEAK_BIT]; // R14
    assign range_single_ref = cfg_reg[RANGE_BIT]; // R15
    assign coding_binary = cfg_reg[CODING_BIT]; // R16

    // ------------------------------------------------------------
    // System domain: power sequencing
    // ------------------------------------------------------------
    logic asleep_reg; // Analog core powered down
    logic asleep_next;
    logic [5:0] wake_reg; // Cycles left before a valid conversion
    logic [5:0] wake_next;

    // Auto modes sleep after each result and wake on the next frame
    always_comb begin
        asleep_next = asleep_reg;
        wake_next = wake_reg;
        unique case (power_mode) // R17
            PWR_NORMAL: begin
                asleep_next = 1'b0;
                wake_next = WAKE_ZERO;
            end
            PWR_FULL_SHUTDOWN: begin
                // Config is kept; only a new power field brings it back
                asleep_next = 1'b1;
                wake_next = WAKE_ZERO;
            end
            PWR_AUTO_SHUTDOWN, PWR_AUTO_STANDBY: begin
                if (result_take) begin
                    asleep_next = 1'b1;
                end
                if (start_reg && asleep_reg) begin
                    wake_next = WAKE_CYCLES;
                end else if (wake_reg != WAKE_ZERO) begin
                    wake_next = wake_reg - WAKE_STEP;
                    if (wake_reg == WAKE_STEP) begin
                        asleep_next = 1'b0;
                    end
                end
            end
        endcase
        if (sys_rst) begin
            asleep_next = 1'b0;
            wake_next = WAKE_ZERO;
        end
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        asleep_reg <= asleep_next;
        wake_reg <= wake_next;
    end

    // Standby keeps the bias generator up; shutdown drops it too
    assign analog_powered = (power_mode == PWR_NORMAL) || (!asleep_reg && (power_mode != PWR_FULL_SHUTDOWN)); // R17
    assign bias_powered = (power_mode != PWR_FULL_SHUTDOWN) && (power_mode != PWR_AUTO_SHUTDOWN || !asleep_reg);

endmodule

`default_nettype wire

// >>> test/adc_host_model.sv
// Purpose: Host serial master that frames transfers and collects result words.
// Assumes: Serial clock idles high and runs only inside frames.
// Notes:   In a full frame the command line shows the inverse of its last bit after edge 16, and that bit again once released.
`default_nettype none

module adc_host_model (
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout_o,
    input wire logic dout_oe,
    // Received result word
    output logic [15:0] got_word,
    output logic got_stb
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins before the first frame
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        got_word = 16'h0000;
        got_stb = 1'b0;
    end

    // One transfer of n falling edges; n below 16 aborts the frame
    task automatic frame(input logic [15:0] w, input int n);
        #7;
        cs_n = 1'b0;
        din = w[15];
        #24;
        for (int i = 0; i < n; i++) begin
            // Undriven line reads unknown and never matches
            got_word[15 - i] = dout_oe ? dout_o : 1'bx;
            sclk = 1'b0;
            #24;
            din = (i < 15) ? w[14 - i] : ~din;
            sclk = 1'b1;
            #24;
        end
        cs_n = 1'b1;
        din = ~din;
        if (n == 16) begin
            got_stb = 1'b1;
            #1;
            got_stb = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// >>> test/adc_serial_control_word_assertions.sv
// Purpose: Port-level checker for the serial control word block.
// Assumes: Bound to the block's top module.
// Notes:   Link checks sample on serial clock falling edges.
`default_nettype none

module adc_scw_checker
    import adc_ctrl_pkg::*;
(
    // Clocks, reset and link
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout_oe,
    input wire logic dout_weak,
    input wire logic [3:0] mux_chan,
    // Core side
    input wire logic conv_start,
    input wire logic [11:0] conversion_config_word,
    input wire logic cfg_update,
    input wire logic [3:0] chan_addr,
    input wire power_mode_e power_mode,
    input wire seq_mode_e seq_mode,
    input wire logic weak_idle,
    input wire logic range_single_ref,
    input wire logic coding_binary,
    input wire logic analog_powered,
    input wire logic bias_powered
);
    logic [4:0] edge_cnt; // Falling edges seen in this frame

    // Edge count, cleared while deselected, saturating
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            edge_cnt <= 5'h00;
        end else if (edge_cnt != 5'h1f) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    chan_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        chan_addr == conversion_config_word[ADDR_HI:ADDR_LO]) else $error("channel decode wrong");
    power_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        power_mode == power_mode_e'(conversion_config_word[PWR_HI:PWR_LO]) && (power_mode == PWR_AUTO_SHUTDOWN
        || bias_powered == (power_mode != PWR_FULL_SHUTDOWN) && (power_mode != PWR_NORMAL || analog_powered)))
        else $error("power decode wrong");
    seq_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_mode == seq_mode_e'({conversion_config_word[SEQ_BIT], conversion_config_word[CHSET_BIT]}))
        else $error("sequencer decode wrong");
    flag_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        {weak_idle, range_single_ref, coding_binary} == conversion_config_word[2:0]) else $error("flag decode wrong");
    cfg_change_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $changed(conversion_config_word) |-> cfg_update) else $error("config changed without update");
    update_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_update |=> !cfg_update) else $error("update pulse too long");
    start_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_start |=> !conv_start) else $error("start pulse too long");
    mux_edge_a: assert property (@(negedge sclk) disable iff (sys_rst)
        $changed(mux_chan) |-> edge_cnt == 5'h0e) else $error("mux moved off edge 14");
    frame_drive_a: assert property (@(negedge sclk) disable iff (sys_rst)
        !cs_n && edge_cnt < 5'h10 |-> dout_oe && !dout_weak) else $error("result line undriven");
endmodule

bind adc_serial_control_word adc_scw_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .dout_oe(dout_oe), .dout_weak(dout_weak), .mux_chan(mux_chan), .conv_start(conv_start),
    .conversion_config_word(conversion_config_word), .cfg_update(cfg_update), .chan_addr(chan_addr),
    .power_mode(power_mode), .seq_mode(seq_mode), .weak_idle(weak_idle), .range_single_ref(range_single_ref),
    .coding_binary(coding_binary), .analog_powered(analog_powered), .bias_powered(bias_powered));

`default_nettype wire

// >>> test/adc_serial_control_word_bench.sv
// Purpose: Self-checking bench for the serial control word block.
// Assumes: Host model drives the link; the bench plays the conversion core.
// Notes:   Channel prediction follows the sequencer run choice.
`default_nettype none

module adc_serial_control_word_bench
    import adc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
        $display("ERROR %s expected %h seen %h", nm, e, g); end end

    logic ref_clk = 1'b0, sys_rst = 1'b1, conv_result_valid = 1'b0, conv_result_ready;
    logic sclk, cs_n, din, dout_o, dout_oe, dout_weak, got_stb, run = 1'b0;
    logic [11:0] conv_result = 12'h000, conversion_config_word, cfg_s = CFG_RESET;
    logic [3:0] mux_chan, chan = 4'h0, last = 4'h0;
    logic [15:0] got_word, exp_w, exp_q[$];
    logic [31:0] seed = 32'h0000_4e3e, rv;
    int bad_count = 0, tests_run = 0;

    // Clock
    always #20 ref_clk = ~ref_clk;

    adc_serial_control_word DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .dout_oe(dout_oe), .dout_weak(dout_weak), .mux_chan(mux_chan), .conv_result(conv_result),
        .conv_result_valid(conv_result_valid), .conv_result_ready(conv_result_ready), .conv_start(),
        .conversion_config_word(conversion_config_word), .cfg_update(), .chan_addr(), .power_mode(),
        .seq_mode(), .weak_idle(), .range_single_ref(), .coding_binary(), .analog_powered(), .bias_powered());
    adc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
        .got_word(got_word), .got_stb(got_stb));

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Compare each received frame with the oldest note
    always @(posedge got_stb) begin
        exp_w = exp_q.pop_front();
        `CHK("dout frame", exp_w, got_word)
    end

    // Offer a result, run one frame, then predict channel and config
    task automatic xfer(input logic [11:0] cfg, input int n);
        logic [31:0] r;
        logic [1:0] m;
        r = rnd();
        @(negedge ref_clk);
        conv_result = r[27:16];
        conv_result_valid = 1'b1;
        repeat (60) begin
            @(negedge ref_clk);
            if (conv_result_ready === 1'b1) break;
        end
        `CHK("ready", 1'b1, conv_result_ready)
        @(negedge ref_clk);
        conv_result_valid = 1'b0;
        if (n == 16) exp_q.push_back({chan, r[27:16]});
        host.frame({cfg, r[3:0]}, n);
        if (n == 16) begin
            if (cfg[WRITE_BIT]) cfg_s = cfg;
            m = {cfg_s[SEQ_BIT], cfg_s[CHSET_BIT]};
            if (cfg[WRITE_BIT] && m == 2'b11) begin
                run = 1'b1;
                last = cfg_s[ADDR_HI:ADDR_LO];
                chan = 4'h0;
            end else if (run && m[1]) begin
                chan = (chan == last) ? 4'h0 : chan + 4'h1;
            end else begin
                run = 1'b0;
                chan = cfg_s[ADDR_HI:ADDR_LO];
            end
        end
        #150;
        `CHK("config", cfg_s, conversion_config_word)
        `CHK("mux", chan, mux_chan)
        if (n == 16) `CHK("idle", {cfg_s[2], cfg_s[2], cfg_s[2] & chan[3]}, {dout_oe, dout_weak, dout_oe & dout_o})
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (int c = 0; c < 16; c++) begin
            rv = rnd();
            xfer({2'b10, 4'(c), 2'(c), 1'b0, rv[2:0]}, 16);
        end
        rv = rnd();
        xfer({1'b0, rv[10:0]}, 16);
        xfer({2'b10, 4'h5, 6'h30}, 8);
        xfer({2'b11, 4'h2, 2'b11, 4'b1100}, 16);
        repeat (4) xfer(12'h000, 16);
        xfer({2'b11, 4'h7, 2'b11, 4'b0101}, 16);
        xfer({2'b10, 4'h9, 2'b11, 4'b1000}, 16);
        xfer({2'b10, 4'hc, 6'h34}, 16);
        xfer({2'b10, 4'h3, 6'h30}, 16);
        give_verdict();
    end

    // Watchdog against a hung handshake
    initial begin
        #200_000;
        bad_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
